// >>> iat_ctrl.sv
// Interrupt acknowledge controller with the two test inputs, APB register slave.
// Assumes the core sequencer pulses instr_done at each instruction boundary, holds off
// its next instruction while core_hold is high, and performs the stack pushes it is told.
//
// Function
// - Acknowledgeable: request set and mask clear.
// - Vector only with enable; block low under high.
// - Service start 7..32 or 8..33 clocks.
// - Divide delays acknowledge until it finishes.
// - High group first, then fixed default order.
// - Unaccepted requests stay pending until acceptable.
// - Maskable accept: push, clear enable, copy priority.
// - Interrupt return restores status word and counter.
// - Break: push, clear enable, vector 003EH.
// - Fixed order plus two-level programmable priority.
// - Service priority flag 0 high or non-maskable, 1 otherwise.
// - No nesting under non-maskable; maskable nesting gated.
// - Flag-altering instructions defer acknowledge one instruction.
// - During break only non-maskable accepted.
// - Request flags set regardless of priority.
// - Test event sets flag, releases standby, no vector.
// - Watch overflow and key edge set test flags.
// - Test request register resets to 00H, RW.
// - Test mask resets FFH, gates watch release.
// - Non-maskable accept clears enable and priority flags.
// - Repeated non-maskable requests collapse into one.
`timescale 1ns/1ps
`include "iat_consts.svh"

module iat_ctrl #(
  parameter int N_SRC = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_SRC-1:0]  src_event,
  input  wire logic              nmi_event,
  input  wire logic              watch_overflow_test_input,
  input  wire logic              key_edge_test_input,
  input  wire logic              instr_done,
  input  wire logic              instr_reserve,
  input  wire logic              break_exec,
  input  wire logic              interrupt_return_exec,
  input  wire logic              psw_load,
  input  wire logic [7:0]        psw_load_data,
  output logic                   accept_enable_flag,
  output logic                   in_service_priority_flag,
  output logic                   core_hold,
  output logic                   push_psw,
  output logic                   push_pc,
  output logic                   vector_load,
  output logic      [15:0]       vector_addr,
  output logic                   standby_release
);

  localparam logic [4:0] SEQ_LAST_HI = 5'(`IAT_SVC_MIN_HI - 2);
  localparam logic [4:0] SEQ_LAST_LO = 5'(`IAT_SVC_MIN_LO - 2);
  localparam int         IDX_W       = (N_SRC > 1) ? $clog2(N_SRC) : 1;

  logic [N_SRC-1:0]  req_ff;
  logic [N_SRC-1:0]  mask_ff;
  logic [N_SRC-1:0]  prio_ff;
  logic [7:0]        treq_ff;
  logic [7:0]        tmask_ff;
  logic              ie_ff;
  logic              isp_ff;
  logic              nmi_pend_ff;
  logic              nmi_svc_ff;
  logic              arm_ff;
  iat_pkg::iat_state_t state_ff;
  iat_pkg::iat_kind_t  kind_ff;
  logic [4:0]        cnt_ff;
  logic [4:0]        last_ff;
  logic [15:0]       vec_ff;
  logic              push_psw_ff;
  logic              push_pc_ff;
  logic              vec_load_ff;
  logic [15:0]       vec_out_ff;
  logic              release_ff;
  logic [31:0]       rdata_ff;

  logic              apb_wr;
  logic              apb_rd;
  logic              hit_req;
  logic              hit_mask;
  logic              hit_prio;
  logic              hit_treq;
  logic              hit_tmask;
  logic              hit_status;
  logic              mapped;
  logic              ctrl_wr;
  logic [N_SRC-1:0]  pending;
  logic [N_SRC-1:0]  eligible;
  logic [N_SRC-1:0]  hi_group;
  logic              any_hi;
  logic [N_SRC-1:0]  pick_vec;
  logic [IDX_W-1:0]  pick_idx;
  logic              pick_lo;
  logic              boundary_ok;
  logic              take_nmi;
  logic              take_mask;
  logic              take_break;
  logic              take_any;
  logic [N_SRC-1:0]  ack_clr;
  logic [7:0]        status_bits;
  logic [31:0]       rd_mux;

  // Lowest index wins: it is the fixed default order inside a priority group.
  function automatic logic [IDX_W-1:0] first_set(input logic [N_SRC-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  assign apb_wr     = psel & penable & pwrite;
  // Read data is captured in the setup phase, so prdata comes from a flop with no wait state.
  assign apb_rd     = psel & ~penable & ~pwrite;
  assign hit_req    = (paddr == `IAT_OFF_REQ);
  assign hit_mask   = (paddr == `IAT_OFF_MASK);
  assign hit_prio   = (paddr == `IAT_OFF_PRIO);
  assign hit_treq   = (paddr == `IAT_OFF_TREQ);
  assign hit_tmask  = (paddr == `IAT_OFF_TMASK);
  assign hit_status = (paddr == `IAT_OFF_STATUS);
  assign mapped     = hit_req | hit_mask | hit_prio | hit_treq | hit_tmask | hit_status;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~mapped;
  assign ctrl_wr    = apb_wr & (hit_req | hit_mask | hit_prio | hit_treq | hit_tmask);

  assign status_bits = {3'h0, (state_ff != iat_pkg::IAT_SEQ_IDLE), nmi_svc_ff,
                        nmi_pend_ff, isp_ff, ie_ff};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (apb_rd)
    begin
      if (hit_req)
      begin
        rd_mux[N_SRC-1:0] = req_ff;
      end
      else if (hit_mask)
      begin
        rd_mux[N_SRC-1:0] = mask_ff;
      end
      else if (hit_prio)
      begin
        rd_mux[N_SRC-1:0] = prio_ff;
      end
      else if (hit_treq)
      begin
        rd_mux[7:0] = treq_ff;
      end
      else if (hit_tmask)
      begin
        rd_mux[7:0] = tmask_ff;
      end
      else if (hit_status)
      begin
        rd_mux[7:0] = status_bits;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= rd_mux;
    end
  end

  // An instruction that touches the status word or interrupt registers blocks its own
  // boundary; the boundary after the next instruction is then open again.
  assign boundary_ok = instr_done & ~instr_reserve & ~arm_ff & ~ctrl_wr;

  assign pending  = req_ff & ~mask_ff;
  assign eligible = (ie_ff & ~nmi_svc_ff) ?
                    (pending & (~prio_ff | {N_SRC{isp_ff}})) : '0;
  assign hi_group = eligible & ~prio_ff;
  assign any_hi   = |hi_group;
  assign pick_vec = any_hi ? hi_group : eligible;
  assign pick_idx = first_set(pick_vec);
  assign pick_lo  = prio_ff[pick_idx];

  assign take_break = break_exec & (state_ff == iat_pkg::IAT_SEQ_IDLE);
  assign take_nmi   = ~take_break & boundary_ok & nmi_pend_ff & ~nmi_svc_ff &
                      (state_ff == iat_pkg::IAT_SEQ_IDLE);
  assign take_mask  = ~take_break & ~take_nmi & boundary_ok & (|eligible) &
                      (state_ff == iat_pkg::IAT_SEQ_IDLE);
  assign take_any   = take_break | take_nmi | take_mask;
  assign ack_clr    = take_mask ? (N_SRC'(1) << pick_idx) : '0;

  // A flag event in the same cycle as a clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_ff   <= N_SRC'(`IAT_RST_REQ);
      mask_ff  <= N_SRC'(`IAT_RST_MASK);
      prio_ff  <= N_SRC'(`IAT_RST_PRIO);
      treq_ff  <= `IAT_RST_TREQ;
      tmask_ff <= `IAT_RST_TMASK;
    end
    else
    begin
      req_ff <= ((apb_wr && hit_req) ? pwdata[N_SRC-1:0] : (req_ff & ~ack_clr))
                | src_event;
      if (apb_wr && hit_mask)
      begin
        mask_ff <= pwdata[N_SRC-1:0];
      end
      if (apb_wr && hit_prio)
      begin
        prio_ff <= pwdata[N_SRC-1:0];
      end
      treq_ff <= ((apb_wr && hit_treq) ? pwdata[7:0] : treq_ff)
                 | {6'h00, key_edge_test_input, watch_overflow_test_input};
      if (apb_wr && hit_tmask)
      begin
        tmask_ff <= pwdata[7:0];
      end
    end
  end

  // Release is a one-cycle pulse per unmasked test event; the test flags never vector.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      release_ff <= 1'b0;
    end
    else
    begin
      release_ff <= (watch_overflow_test_input & ~tmask_ff[`IAT_TST_WATCH_BIT]) |
                    (key_edge_test_input & ~tmask_ff[`IAT_TST_KEY_BIT]);
    end
  end

  // Status word flags: acceptance has priority over a core load in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_ff  <= `IAT_RST_IE;
      isp_ff <= `IAT_RST_ISP;
    end
    else if (take_any)
    begin
      ie_ff <= 1'b0;
      if (take_nmi)
      begin
        isp_ff <= 1'b0;
      end
      else if (take_mask)
      begin
        isp_ff <= pick_lo;
      end
    end
    else if (psw_load)
    begin
      ie_ff  <= psw_load_data[`IAT_PSW_IE_BIT];
      isp_ff <= psw_load_data[`IAT_PSW_ISP_BIT];
    end
  end

  // Extra requests during non-maskable service fold into the single pending bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_pend_ff <= 1'b0;
      nmi_svc_ff  <= 1'b0;
      arm_ff      <= 1'b0;
    end
    else
    begin
      nmi_pend_ff <= nmi_event | (nmi_pend_ff & ~take_nmi);
      nmi_svc_ff  <= take_nmi | (nmi_svc_ff & ~interrupt_return_exec);
      arm_ff      <= ctrl_wr | (arm_ff & ~instr_done);
    end
  end

  // The save sequence is sized so the vector loads a fixed number of clocks after acceptance,
  // one more for a low-priority maskable; the rest of the latency is the core reaching its boundary.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= iat_pkg::IAT_SEQ_IDLE;
      kind_ff  <= iat_pkg::IAT_KIND_NONE;
      cnt_ff   <= 5'h00;
      last_ff  <= 5'h00;
      vec_ff   <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        iat_pkg::IAT_SEQ_IDLE:
        begin
          cnt_ff <= 5'h00;
          if (take_any)
          begin
            state_ff <= iat_pkg::IAT_SEQ_SAVE;
            last_ff  <= (take_mask && pick_lo) ? SEQ_LAST_LO : SEQ_LAST_HI;
            if (take_break)
            begin
              kind_ff <= iat_pkg::IAT_KIND_BREAK;
              vec_ff  <= `IAT_VEC_BREAK;
            end
            else if (take_nmi)
            begin
              kind_ff <= iat_pkg::IAT_KIND_NMI;
              vec_ff  <= `IAT_VEC_NMI;
            end
            else
            begin
              kind_ff <= iat_pkg::IAT_KIND_MASK;
              vec_ff  <= `IAT_VEC_MASK_BASE + {15'h0000, 1'b0} + 16'({pick_idx, 1'b0});
            end
          end
        end
        iat_pkg::IAT_SEQ_SAVE:
        begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == last_ff)
          begin
            state_ff <= iat_pkg::IAT_SEQ_IDLE;
            kind_ff  <= iat_pkg::IAT_KIND_NONE;
          end
        end
        default:
        begin
          state_ff <= iat_pkg::IAT_SEQ_IDLE;
        end
      endcase
    end
  end

  // Pushes come status word first, then program counter, then the vector load.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      push_psw_ff <= 1'b0;
      push_pc_ff  <= 1'b0;
      vec_load_ff <= 1'b0;
      vec_out_ff  <= 16'h0000;
    end
    else
    begin
      push_psw_ff <= (state_ff == iat_pkg::IAT_SEQ_SAVE) && (cnt_ff == `IAT_SEQ_PSW);
      push_pc_ff  <= (state_ff == iat_pkg::IAT_SEQ_SAVE) && (cnt_ff == `IAT_SEQ_PC);
      vec_load_ff <= (state_ff == iat_pkg::IAT_SEQ_SAVE) && (cnt_ff == last_ff);
      if ((state_ff == iat_pkg::IAT_SEQ_SAVE) && (cnt_ff == last_ff))
      begin
        vec_out_ff <= vec_ff;
      end
    end
  end

  assign prdata                   = rdata_ff;
  assign accept_enable_flag       = ie_ff;
  assign in_service_priority_flag = isp_ff;
  assign core_hold                = (state_ff != iat_pkg::IAT_SEQ_IDLE) | take_any;
  assign push_psw                 = push_psw_ff;
  assign push_pc                  = push_pc_ff;
  assign vector_load              = vec_load_ff;
  assign vector_addr              = vec_out_ff;
  assign standby_release          = release_ff;

endmodule

// >>> iat_consts.svh
// Named constants for the interrupt acknowledge and test input block.
// Assumes it is included by bare name into the design file and the bench.
`ifndef IAT_CONSTS_SVH
`define IAT_CONSTS_SVH

`define IAT_OFF_REQ        12'h000
`define IAT_OFF_MASK       12'h004
`define IAT_OFF_PRIO       12'h008
`define IAT_OFF_TREQ       12'h00c
`define IAT_OFF_TMASK      12'h010
`define IAT_OFF_STATUS     12'h014

`define IAT_RST_REQ        32'h0000_0000
`define IAT_RST_MASK       32'hffff_ffff
`define IAT_RST_PRIO       32'hffff_ffff
`define IAT_RST_TREQ       8'h00
`define IAT_RST_TMASK      8'hff
`define IAT_RST_IE         1'h0
`define IAT_RST_ISP        1'h1

`define IAT_PSW_IE_BIT     7
`define IAT_PSW_ISP_BIT    1
`define IAT_TST_WATCH_BIT  0
`define IAT_TST_KEY_BIT    1

`define IAT_ST_IE_BIT      0
`define IAT_ST_ISP_BIT     1
`define IAT_ST_NMIP_BIT    2
`define IAT_ST_NMIS_BIT    3
`define IAT_ST_BUSY_BIT    4

`define IAT_VEC_BREAK      16'h003e
`define IAT_VEC_NMI        16'h0004
`define IAT_VEC_MASK_BASE  16'h0006

`define IAT_CLK_NS         8
`define IAT_SVC_MIN_HI     7
`define IAT_SVC_MIN_LO     8
`define IAT_SEQ_PSW        5'h00
`define IAT_SEQ_PC         5'h01

`endif

// >>> iat_pkg.sv
// Types shared by the interrupt acknowledge and test input block.
// Assumes nothing outside itself.
package iat_pkg;

  typedef enum logic [1:0] {
    IAT_SEQ_IDLE,
    IAT_SEQ_SAVE
  } iat_state_t;

  typedef enum logic [1:0] {
    IAT_KIND_NONE,
    IAT_KIND_NMI,
    IAT_KIND_MASK,
    IAT_KIND_BREAK
  } iat_kind_t;

endpackage

// >>> iat_core_model.sv
// Core sequencer model that gives the acknowledge controller its instruction boundaries.
// Assumes one clock; the instruction count stalls while core_hold is high.
`timescale 1ns/1ps
module iat_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic core_hold,
  input  wire logic slow,
  input  wire logic rsv,
  output logic      instr_done,
  output logic      instr_reserve
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  // A divide runs long, so a request that lands just before it waits the longest.
  assign nxt_cnt = instr_done ? 5'h00 : (core_hold ? cnt_ff : cnt_ff + 5'h01);
  assign instr_done = (cnt_ff == (slow ? 5'h13 : 5'h02));
  assign instr_reserve = instr_done & rsv;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 5'h00;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

// >>> iat_ctrl_chk.sv
// Assertions on the acknowledge controller ports, bound into every instance.
// Assumes the core runs one accept sequence at a time.
`timescale 1ns/1ps
module iat_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        instr_done,
  input wire logic        instr_reserve,
  input wire logic        break_exec,
  input wire logic        watch_overflow_test_input,
  input wire logic        key_edge_test_input,
  input wire logic        accept_enable_flag,
  input wire logic        in_service_priority_flag,
  input wire logic        core_hold,
  input wire logic        push_psw,
  input wire logic        push_pc,
  input wire logic        vector_load,
  input wire logic [15:0] vector_addr,
  input wire logic        standby_release
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PC_AFTER_PSW: assert property (push_psw |=> push_pc)
    else $error("counter push missing after status push");
  AST_VEC_TIME: assert property (push_psw |-> ##[5:6] vector_load)
    else $error("vector load late after status push");
  AST_PUSH_STATE: assert property (push_psw |-> core_hold && !accept_enable_flag)
    else $error("status push outside a held accept");
  AST_BRK_VEC: assert property (break_exec |->
    ##[5:8] (vector_load && vector_addr == 16'h003e))
    else $error("break vector missing");
  AST_REL_CAUSE: assert property (standby_release |->
    $past(watch_overflow_test_input || key_edge_test_input))
    else $error("standby release without a test event");
  AST_HOLD_CAUSE: assert property ($rose(core_hold) |->
    (instr_done && !instr_reserve) || break_exec)
    else $error("accept outside an open boundary");
  AST_VEC_ONE: assert property (vector_load |=> !vector_load && $stable(vector_addr))
    else $error("vector load not a single pulse");
  AST_NMI_FLAGS: assert property (vector_load && vector_addr == 16'h0004 |->
    !accept_enable_flag && !in_service_priority_flag)
    else $error("flags not cleared on non-maskable vector");
  COV_BRK: cover property (vector_load && vector_addr == 16'h003e);
  COV_NMI: cover property (vector_load && vector_addr == 16'h0004);
  COV_REL: cover property (standby_release);
endmodule
bind iat_ctrl iat_ctrl_chk iat_ctrl_chk_inst (.pclk, .presetn, .instr_done, .instr_reserve,
  .break_exec, .watch_overflow_test_input, .key_edge_test_input, .accept_enable_flag,
  .in_service_priority_flag, .core_hold, .push_psw, .push_pc, .vector_load, .vector_addr,
  .standby_release);

// >>> tb_iat_ctrl.sv
// Self-checking bench for the interrupt acknowledge controller.
// Assumes the core model gives boundaries; the APB master and event sources live here.
`timescale 1ns/1ps
`include "iat_consts.svh"
module tb_iat_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rel_cnt, vec_cnt;
  logic [7:0]  src_event, psw_load_data;
  logic        nmi_event, watch_overflow_test_input, key_edge_test_input, break_exec;
  logic        interrupt_return_exec, psw_load, instr_done, instr_reserve, slow, rsv;
  logic        accept_enable_flag, in_service_priority_flag, core_hold, push_psw, push_pc;
  logic        vector_load, standby_release;
  logic [15:0] vector_addr;
  int          mismatches, checks, cyc;

  iat_ctrl #(.N_SRC(8)) iat_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_event, .nmi_event, .watch_overflow_test_input,
    .key_edge_test_input, .instr_done, .instr_reserve, .break_exec, .interrupt_return_exec, .psw_load,
    .psw_load_data, .accept_enable_flag, .in_service_priority_flag, .core_hold, .push_psw,
    .push_pc, .vector_load, .vector_addr, .standby_release);
  iat_core_model iat_core_model_inst (.pclk, .presetn, .core_hold, .slow, .rsv, .instr_done,
    .instr_reserve);

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(negedge pclk)
  begin
    if (standby_release === 1'b1)
      rel_cnt++;
    if (vector_load === 1'b1)
      vec_cnt++;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      complete_run;
    end
  end

  task complete_run;
    $display("counts checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chkr(input string nm, input int n, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi)
    begin
      mismatches++;
      $display("unexpected %s expected %0d to %0d seen %0d", nm, lo, hi, n);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Flag order: non-maskable, watch, key, break, interrupt return, status load.
  task ev(input logic [7:0] s, input logic [5:0] f, input logic [7:0] d);
    @(posedge pclk);
    src_event <= s;
    {nmi_event, watch_overflow_test_input, key_edge_test_input} <= f[5:3];
    {break_exec, interrupt_return_exec, psw_load} <= f[2:0];
    psw_load_data <= d;
    @(posedge pclk);
    src_event <= 8'h00;
    {nmi_event, watch_overflow_test_input, key_edge_test_input} <= 3'h0;
    {break_exec, interrupt_return_exec, psw_load} <= 3'h0;
  endtask

  // A zero upper bound means no vector may appear within the window.
  task wv(input logic [15:0] a, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (vector_load !== 1'b1 && n < 40);
    if (hi == 0)
      chk("no_vector", 32'h0, {31'h0, vector_load});
    else
    begin
      chk("vector_addr", {16'h0, a}, {16'h0, vector_addr});
      chkr("latency", n, lo, hi);
    end
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, src_event, psw_load_data} = '0;
    {nmi_event, watch_overflow_test_input, key_edge_test_input} = 3'h0;
    {break_exec, interrupt_return_exec, psw_load, slow, rsv, presetn} = 6'h00;
    {rel_cnt, vec_cnt} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IAT_OFF_TREQ, 32'h0, "treq_reset");
    rdc(`IAT_OFF_TMASK, 32'hff, "tmask_reset");
    rdc(`IAT_OFF_STATUS, 32'h2, "status_reset");
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped_error", 32'h1, {31'h0, er});
    $display("test registers done");
    ev(8'h00, 6'h18, 8'h00);
    rdc(`IAT_OFF_TREQ, 32'h3, "test_flags");
    chk("masked_release", 32'h0, rel_cnt);
    apb(1'b1, `IAT_OFF_TMASK, 32'hfc);
    ev(8'h00, 6'h10, 8'h00);
    ev(8'h00, 6'h08, 8'h00);
    rdc(`IAT_OFF_TREQ, 32'h3, "sticky_flags");
    chk("release_count", 32'h2, rel_cnt);
    apb(1'b1, `IAT_OFF_TREQ, 32'h0);
    rdc(`IAT_OFF_TREQ, 32'h0, "test_clear");
    chk("test_no_vector", 32'h0, vec_cnt);
    $display("test inputs done");
    apb(1'b1, `IAT_OFF_MASK, 32'h0);
    apb(1'b1, `IAT_OFF_PRIO, 32'hfffffff7);
    ev(8'h01, 6'h00, 8'h00);
    wv(16'h0, 0, 0);
    rdc(`IAT_OFF_REQ, 32'h1, "pending_flag");
    ev(8'h00, 6'h01, 8'h82);
    wv(16'h0006, 1, 40);
    rdc(`IAT_OFF_STATUS, 32'h2, "low_service");
    ev(8'h00, 6'h01, 8'h82);
    ev(8'h09, 6'h00, 8'h00);
    wv(16'h000c, 7, 32);
    rdc(`IAT_OFF_STATUS, 32'h0, "high_service");
    chk("accept_enable_flag", 32'h0, {31'h0, accept_enable_flag});
    chk("in_service_priority_flag", 32'h0, {31'h0, in_service_priority_flag});
    ev(8'h01, 6'h01, 8'h80);
    wv(16'h0, 0, 0);
    ev(8'h00, 6'h20, 8'h00);
    wv(16'h0004, 1, 40);
    rdc(`IAT_OFF_STATUS, 32'h8, "nmi_service");
    ev(8'h00, 6'h20, 8'h00);
    ev(8'h00, 6'h21, 8'h82);
    wv(16'h0, 0, 0);
    ev(8'h00, 6'h02, 8'h00);
    wv(16'h0004, 1, 40);
    ev(8'h00, 6'h03, 8'h82);
    wv(16'h0006, 1, 40);
    ev(8'h00, 6'h01, 8'h82);
    ev(8'h02, 6'h00, 8'h00);
    wv(16'h0008, 8, 33);
    @(posedge pclk) rsv <= 1'b1;
    ev(8'h08, 6'h01, 8'h82);
    wv(16'h0, 0, 0);
    @(posedge pclk) rsv <= 1'b0;
    wv(16'h000c, 1, 40);
    ev(8'h00, 6'h01, 8'h82);
    ev(8'h00, 6'h04, 8'h00);
    wv(16'h003e, 1, 40);
    rdc(`IAT_OFF_STATUS, 32'h2, "break_service");
    ev(8'h08, 6'h00, 8'h00);
    wv(16'h0, 0, 0);
    @(posedge pclk) slow <= 1'b1;
    ev(8'h00, 6'h01, 8'h82);
    wv(16'h000c, 1, 40);
    $display("test acknowledge done");
    complete_run;
  end
endmodule
